// [hdl/lcdlp_top.sv]
// Notes on behaviour
// - The interval A power field picks off, low, medium or high ladder drive during interval A.
// - The interval B power field picks the ladder drive during interval B with the same code.
// - The interval A length field counts how many low-frequency clocks interval A lasts.
// - With Type-A, length zero means always B, else n clocks of A then 16 minus n of B.
// - Ladder control bit 3 reads zero and every field resets to zero.
// - An interrupt is raised when the active flag falls from one to zero.
// - A frame starts at the leading edge of the first common line.
// - The frame flag sets once all pixel data of the frame has been read, before the boundary.
// - In Type-B the frame interrupt comes only at the end of whole phase intervals; here it comes once in every frame.
// - A pixel write while writes are disabled is dropped and sets the write-error flag.
// - No frame interrupt with Type-A, nor with Type-B in static drive.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "lcdlp_defs.svh"

module lcdlp_top #(
    parameter int LF_DIV = `LCDLP_LF_DIV,
    parameter int FRAME_CLKS = 32,
    parameter int FETCH_CLKS = 28,
    parameter int PIX_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] ladder_power,
    output logic ladder_in_a,
    output logic first_common_line,
    output logic [PIX_W-1:0] pixel_out,
    output logic irq
);

    // ==========================================
    // Registers and bus decode
    // ==========================================
    logic [7:0] ladder_r;
    logic enable_r;
    logic wft_r;
    logic [1:0] mux_r;
    logic active_r;
    logic pixel_write_error_flag_flag_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [PIX_W-1:0] pixel_r;
    logic [PIX_W-1:0] pixel_out_r;
    logic [5:0] per_cnt_r;
    logic [15:0] div_cnt_r;
    logic [7:0] frm_cnt_r;
    logic write_open_r;
    logic lf_tick;
    logic wr_acc;
    logic rd_acc;
    logic frame_irq_ok;
    logic frame_start;
    logic fetch_done;
    logic shut_evt;
    logic pix_bad_wr;
    logic [5:0] period_len;
    logic [31:0] rdata_nxt;
    logic mapped;
    lcdlp_pkg::lcdlp_state_t state_r;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign mapped = hit(paddr, `LCDLP_OFF_LADDER) || hit(paddr, `LCDLP_OFF_MAIN) ||
                    hit(paddr, `LCDLP_OFF_STATUS) || hit(paddr, `LCDLP_OFF_MASK) ||
                    hit(paddr, `LCDLP_OFF_PIXEL) || hit(paddr, `LCDLP_OFF_TIMING);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_r <= `LCDLP_LAD_RESET;
        end else if (wr_acc && pready && hit(paddr, `LCDLP_OFF_LADDER)) begin
            ladder_r <= pwdata[7:0] & `LCDLP_LAD_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= 1'b0;
            wft_r <= 1'b0;
            mux_r <= 2'h0;
        end else if (wr_acc && pready && hit(paddr, `LCDLP_OFF_MAIN)) begin
            enable_r <= pwdata[`LCDLP_MAIN_EN];
            wft_r <= pwdata[`LCDLP_MAIN_WFT];
            mux_r <= pwdata[`LCDLP_MAIN_MUX_HI:`LCDLP_MAIN_MUX_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 3'h0;
        end else if (wr_acc && pready && hit(paddr, `LCDLP_OFF_MASK)) begin
            mask_r <= pwdata[2:0];
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(paddr, `LCDLP_OFF_LADDER)) begin
            rdata_nxt[7:0] = ladder_r;
        end else if (hit(paddr, `LCDLP_OFF_MAIN)) begin
            rdata_nxt[`LCDLP_MAIN_EN] = enable_r;
            rdata_nxt[`LCDLP_MAIN_WFT] = wft_r;
            rdata_nxt[`LCDLP_MAIN_MUX_HI:`LCDLP_MAIN_MUX_LO] = mux_r;
            rdata_nxt[`LCDLP_MAIN_ACTIVE] = active_r;
            rdata_nxt[`LCDLP_MAIN_PIXEL_WRITE_ERROR_FLAG] = pixel_write_error_flag_flag_r;
        end else if (hit(paddr, `LCDLP_OFF_STATUS)) begin
            rdata_nxt[2:0] = status_r;
        end else if (hit(paddr, `LCDLP_OFF_MASK)) begin
            rdata_nxt[2:0] = mask_r;
        end else if (hit(paddr, `LCDLP_OFF_PIXEL)) begin
            rdata_nxt[PIX_W-1:0] = pixel_r;
        end else if (hit(paddr, `LCDLP_OFF_TIMING)) begin
            rdata_nxt[5:0] = per_cnt_r;
            rdata_nxt[8] = write_open_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata <= rdata_nxt;
        end
    end

    // ==========================================
    // Low-frequency tick and controller state
    // ==========================================
    assign lf_tick = (div_cnt_r == 16'(LF_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 16'h0000;
        end else if (lf_tick || state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            div_cnt_r <= 16'h0000;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // Shutdown finishes at a frame boundary so the glass is left without DC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= lcdlp_pkg::LCDLP_ST_IDLE;
        end else begin
            unique case (state_r)
                lcdlp_pkg::LCDLP_ST_IDLE: begin
                    if (enable_r) begin
                        state_r <= lcdlp_pkg::LCDLP_ST_RUN;
                    end
                end
                lcdlp_pkg::LCDLP_ST_RUN: begin
                    if (!enable_r) begin
                        state_r <= lcdlp_pkg::LCDLP_ST_STOPPING;
                    end
                end
                lcdlp_pkg::LCDLP_ST_STOPPING: begin
                    if (enable_r) begin
                        state_r <= lcdlp_pkg::LCDLP_ST_RUN;
                    end else if (frame_start) begin
                        state_r <= lcdlp_pkg::LCDLP_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= lcdlp_pkg::LCDLP_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
        end else begin
            active_r <= (state_r != lcdlp_pkg::LCDLP_ST_IDLE);
        end
    end

    assign shut_evt = active_r && (state_r == lcdlp_pkg::LCDLP_ST_IDLE);

    // ==========================================
    // Ladder power sequencing
    // ==========================================
    assign period_len = wft_r ? `LCDLP_PERIOD_B : `LCDLP_PERIOD_A;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_r <= 6'd0;
        end else if (state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            per_cnt_r <= 6'd0;
        end else if (lf_tick) begin
            if (per_cnt_r >= period_len - 6'd1) begin
                per_cnt_r <= 6'd0;
            end else begin
                per_cnt_r <= per_cnt_r + 6'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_in_a <= 1'b0;
            ladder_power <= 2'h0;
        end else if (state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            ladder_in_a <= 1'b0;
            ladder_power <= 2'h0;
        end else if (per_cnt_r < {3'd0, ladder_r[`LCDLP_LAD_LEN_HI:`LCDLP_LAD_LEN_LO]}) begin
            ladder_in_a <= 1'b1;
            ladder_power <= ladder_r[`LCDLP_LAD_A_HI:`LCDLP_LAD_A_LO];
        end else begin
            ladder_in_a <= 1'b0;
            ladder_power <= ladder_r[`LCDLP_LAD_B_HI:`LCDLP_LAD_B_LO];
        end
    end

    // ==========================================
    // Frame timing and pixel writes
    // ==========================================
    // Frames count FRAME_CLKS low-frequency clocks whatever the waveform type, so Type-B interrupts come once per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_cnt_r <= 8'd0;
        end else if (state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            frm_cnt_r <= 8'd0;
        end else if (lf_tick) begin
            if (frm_cnt_r == 8'(FRAME_CLKS - 1)) begin
                frm_cnt_r <= 8'd0;
            end else begin
                frm_cnt_r <= frm_cnt_r + 8'd1;
            end
        end
    end

    assign frame_start = lf_tick && (frm_cnt_r == 8'(FRAME_CLKS - 1));
    assign fetch_done = lf_tick && (frm_cnt_r == 8'(FETCH_CLKS - 1));
    assign frame_irq_ok = wft_r && (mux_r != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_common_line <= 1'b0;
        end else if (state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            first_common_line <= 1'b0;
        end else if (frame_start) begin
            first_common_line <= 1'b1;
        end else if (lf_tick) begin
            first_common_line <= 1'b0;
        end
    end

    // Window opens at the interrupt and closes when the next fetch begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_open_r <= 1'b1;
        end else if (!frame_irq_ok || state_r == lcdlp_pkg::LCDLP_ST_IDLE) begin
            write_open_r <= 1'b1;
        end else if (fetch_done) begin
            write_open_r <= 1'b1;
        end else if (frame_start) begin
            write_open_r <= 1'b0;
        end
    end

    assign pix_bad_wr = wr_acc && pready && hit(paddr, `LCDLP_OFF_PIXEL) && !write_open_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_r <= '0;
        end else if (wr_acc && pready && hit(paddr, `LCDLP_OFF_PIXEL) && write_open_r) begin
            pixel_r <= pwdata[PIX_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_out_r <= '0;
        end else if (frame_start) begin
            pixel_out_r <= pixel_r;
        end
    end

    assign pixel_out = pixel_out_r;

    // Error flag: set wins over clear by writing zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_write_error_flag_flag_r <= 1'b0;
        end else if (pix_bad_wr) begin
            pixel_write_error_flag_flag_r <= 1'b1;
        end else if (wr_acc && pready && hit(paddr, `LCDLP_OFF_MAIN) && !pwdata[`LCDLP_MAIN_PIXEL_WRITE_ERROR_FLAG]) begin
            pixel_write_error_flag_flag_r <= 1'b0;
        end
    end

    // ==========================================
    // Interrupts
    // ==========================================
    logic [2:0] evt;
    logic [2:0] w1c;

    assign evt = {pix_bad_wr, fetch_done && frame_irq_ok, shut_evt};
    assign w1c = (wr_acc && pready && hit(paddr, `LCDLP_OFF_STATUS)) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 3'h0;
        end else begin
            status_r <= evt | (status_r & ~w1c);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((evt | (status_r & ~w1c)) & mask_r);
        end
    end

endmodule

// [hdl/lcdlp_defs.svh]
`ifndef LCDLP_DEFS_SVH
`define LCDLP_DEFS_SVH

// Register byte offsets
`define LCDLP_OFF_LADDER 12'h000
`define LCDLP_OFF_MAIN 12'h004
`define LCDLP_OFF_STATUS 12'h008
`define LCDLP_OFF_MASK 12'h00C
`define LCDLP_OFF_PIXEL 12'h010
`define LCDLP_OFF_TIMING 12'h014

// Ladder control fields
`define LCDLP_LAD_A_HI 7
`define LCDLP_LAD_A_LO 6
`define LCDLP_LAD_B_HI 5
`define LCDLP_LAD_B_LO 4
`define LCDLP_LAD_LEN_HI 2
`define LCDLP_LAD_LEN_LO 0
`define LCDLP_LAD_RESET 8'h00
`define LCDLP_LAD_WMASK 8'hF7

// Main control fields
`define LCDLP_MAIN_EN 0
`define LCDLP_MAIN_WFT 1
`define LCDLP_MAIN_MUX_HI 3
`define LCDLP_MAIN_MUX_LO 2
`define LCDLP_MAIN_ACTIVE 4
`define LCDLP_MAIN_PIXEL_WRITE_ERROR_FLAG 5

// Status and mask bits
`define LCDLP_ST_SHUT 0
`define LCDLP_ST_FRAME 1
`define LCDLP_ST_PIXEL_WRITE_ERROR_FLAG 2

// Period lengths in low-frequency clocks
`define LCDLP_PERIOD_A 6'd16
`define LCDLP_PERIOD_B 6'd32

// Low-frequency tick rate
`define LCDLP_CLK_HZ 40000000
`define LCDLP_LF_HZ 32768
`define LCDLP_LF_DIV (`LCDLP_CLK_HZ / `LCDLP_LF_HZ)

`endif

// [hdl/lcdlp_pkg.sv]
package lcdlp_pkg;

typedef enum logic [1:0] {
    LCDLP_PWR_OFF,
    LCDLP_PWR_LOW,
    LCDLP_PWR_MED,
    LCDLP_PWR_HIGH
} lcdlp_power_t;

typedef enum logic [1:0] {
    LCDLP_ST_IDLE,
    LCDLP_ST_RUN,
    LCDLP_ST_STOPPING
} lcdlp_state_t;

endpackage

// [bench/lcdlp_props.sv]
`timescale 1ns/1ps
`include "lcdlp_defs.svh"
module lcdlp_props #(
    parameter int LF_DIV = 4,
    parameter int PIX_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] ladder_power,
    input wire logic ladder_in_a,
    input wire logic first_common_line,
    input wire logic [PIX_W-1:0] pixel_out,
    input wire logic irq
);
// ==========================================
// Shadow of software settings
logic [7:0] lad_r;
logic wft_r;
logic en_r;
logic [2:0] mask_r;
logic [15:0] quiet_r;
logic [15:0] a_cnt_r;
logic [15:0] p_cnt_r;
wire wr_done = psel && penable && pready && pwrite;
// Long quiet span so a full period has run since the last setting change
wire quiet = quiet_r >= 16'(64 * LF_DIV);
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lad_r <= 8'h00;
        wft_r <= 1'b0;
        en_r <= 1'b0;
        mask_r <= 3'h0;
        quiet_r <= 16'h0000;
    end else begin
        quiet_r <= wr_done ? 16'h0000 : (quiet_r == 16'hFFFF ? quiet_r : quiet_r + 16'h0001);
        if (wr_done && paddr == `LCDLP_OFF_LADDER) lad_r <= pwdata[7:0];
        if (wr_done && paddr == `LCDLP_OFF_MAIN) begin
            wft_r <= pwdata[1];
            en_r <= pwdata[0];
        end
        if (wr_done && paddr == `LCDLP_OFF_MASK) mask_r <= pwdata[2:0];
    end
end
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        a_cnt_r <= 16'h0000;
        p_cnt_r <= 16'h0000;
    end else begin
        a_cnt_r <= ladder_in_a ? a_cnt_r + 16'h0001 : 16'h0000;
        p_cnt_r <= $rose(ladder_in_a) ? 16'h0001 : p_cnt_r + 16'h0001;
    end
end
// ==========================================
// Properties
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
a_pready_answer: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
a_slverr_pair: assert property (pslverr |-> pready && (pwrite || prdata == 32'h00000000))
    else $error("slave error without answer or with data");
// Ladder is parked off while the controller idles, so only check once enabled
a_ladder_power: assert property (
    en_r && quiet_r > 16'h0002 |-> ladder_power == (ladder_in_a ? lad_r[7:6] : lad_r[5:4]))
    else $error("ladder power does not follow interval field");
a_len_zero: assert property (
    quiet_r > 16'h0002 && lad_r[2:0] == 3'h0 |-> !ladder_in_a)
    else $error("interval A entered with zero length");
a_a_length: assert property (
    quiet && $fell(ladder_in_a) |-> a_cnt_r == 16'(lad_r[2:0] * LF_DIV))
    else $error("interval A length wrong");
a_period_len: assert property (
    quiet && $rose(ladder_in_a) |-> p_cnt_r == 16'((wft_r ? 32 : 16) * LF_DIV))
    else $error("waveform period length wrong");
a_irq_masked: assert property (quiet_r > 16'h0002 && mask_r == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
c_interval_a: cover property ($rose(ladder_in_a));
c_irq: cover property ($rose(irq));
c_slverr: cover property (pslverr);
c_frame: cover property ($rose(first_common_line));
endmodule

// [bench/lcdlp_panel.sv]
`timescale 1ns/1ps
module lcdlp_panel #(
    parameter int PIX_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic first_common_line,
    input wire logic [PIX_W-1:0] pixel_out,
    output logic [PIX_W-1:0] shown_pix
);
// ==========================================
// Glass takes segment data only while the first common line is driven
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shown_pix <= '0;
    else if (first_common_line) shown_pix <= pixel_out;
end
endmodule

// [bench/lcd_ladder_power_and_frame_irq_tb.sv]
`timescale 1ns/1ps
`include "lcdlp_defs.svh"
module lcd_ladder_power_and_frame_irq_tb;
localparam int LFD = 4;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h00000000, prdata, rd;
logic pready, pslverr, ladder_in_a, fcl, irq, last_err;
logic [1:0] ladder_power, pa, pb;
logic [7:0] pixel_out, shown, old;
logic [7:0] pix_q[$];
int n_mismatch = 0, total_checks = 0, seed = 32'h6debf2c2;
int lad, len, na, nbad, i, k;
always #12.5 pclk = ~pclk;
lcdlp_top #(.LF_DIV(LFD), .FRAME_CLKS(8), .FETCH_CLKS(6), .PIX_W(8)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ladder_power(ladder_power), .ladder_in_a(ladder_in_a),
    .first_common_line(fcl), .pixel_out(pixel_out), .irq(irq));
lcdlp_panel #(.PIX_W(8)) u_panel (.pclk(pclk), .presetn(presetn), .first_common_line(fcl),
    .pixel_out(pixel_out), .shown_pix(shown));
// ==========================================
// Shared tasks
task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
        n_mismatch++;
        $display("BAD %s exp %h got %h", nm, e, g);
    end
endtask
// Idle edge first, so back-to-back calls never drive psel twice in one step
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin n_mismatch++; results(); end
endtask
task automatic wait_sig(input bit sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? irq : fcl) !== lvl && n < 3000) begin @(posedge pclk); n++; end
    if ((sel ? irq : fcl) !== lvl) begin n_mismatch++; results(); end
endtask
// ==========================================
// Main sequence
initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `LCDLP_OFF_LADDER, 0); chk("ladder_reset", 0, rd);
    lad = $random(seed) & 32'hFF;
    apb(1, `LCDLP_OFF_LADDER, lad);
    apb(0, `LCDLP_OFF_LADDER, 0); chk("ladder_rw", lad & 32'hF7, rd);
    apb(0, 12'h020, 0); chk("unmapped_err", 1, last_err);
    chk("unmapped_data", 0, rd);
    for (i = 0; i < 4; i++) begin
        len = (i == 0) ? 0 : 2 * i + 1;
        pa = 2'(i);
        pb = 2'(3 - i);
        apb(1, `LCDLP_OFF_MAIN, 32'({i[0], 1'b1}));
        apb(1, `LCDLP_OFF_LADDER, 32'({pa, pb, 1'b0, 3'(len)}));
        repeat (300) @(posedge pclk);
        na = 0;
        nbad = 0;
        for (k = 0; k < (i[0] ? 32 : 16) * LFD; k++) begin
            @(posedge pclk);
            if (ladder_in_a === 1'b1) na++;
            if (ladder_power !== (ladder_in_a ? pa : pb)) nbad++;
        end
        chk("a_clocks", 32'(len * LFD), 32'(na));
        chk("power_sel", 0, 32'(nbad));
    end
    apb(1, `LCDLP_OFF_MASK, 32'h2);
    apb(1, `LCDLP_OFF_STATUS, 32'h7);
    apb(1, `LCDLP_OFF_MAIN, 32'h7);
    for (k = 0; k < 2; k++) begin
        wait_sig(1, 1'b1);
        chk("irq_before_frame", 0, fcl);
        old = 8'($random(seed));
        pix_q.push_back(old);
        apb(1, `LCDLP_OFF_PIXEL, old);
        apb(1, `LCDLP_OFF_STATUS, 32'h2);
        apb(0, `LCDLP_OFF_MAIN, 0); chk("active", 1, rd[4]);
        chk("irq_cleared", 0, irq);
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        chk("pixel", pix_q.pop_front(), shown);
    end
    apb(1, `LCDLP_OFF_PIXEL, ~old);
    apb(0, `LCDLP_OFF_MAIN, 0); chk("pixel_write_error_flag_main", 1, rd[5]);
    apb(0, `LCDLP_OFF_STATUS, 0); chk("pixel_write_error_flag_status", 1, rd[2]);
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    chk("pixel_kept", old, shown);
    for (k = 0; k < 2; k++) begin
        apb(1, `LCDLP_OFF_MAIN, k ? 32'h3 : 32'h5);
        apb(1, `LCDLP_OFF_STATUS, 32'h7);
        repeat (3) begin wait_sig(0, 1'b1); wait_sig(0, 1'b0); end
        apb(0, `LCDLP_OFF_STATUS, 0); chk("no_frame_irq", 0, rd[1]);
    end
    apb(1, `LCDLP_OFF_MASK, 32'h1);
    apb(1, `LCDLP_OFF_MAIN, 32'h0);
    wait_sig(1, 1'b1);
    apb(0, `LCDLP_OFF_MAIN, 0); chk("inactive", 0, rd[4]);
    apb(0, `LCDLP_OFF_STATUS, 0); chk("shut_status", 1, rd[0]);
    apb(1, `LCDLP_OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    results();
end
endmodule
bind lcdlp_top lcdlp_props #(.LF_DIV(LF_DIV), .PIX_W(PIX_W)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ladder_power(ladder_power), .ladder_in_a(ladder_in_a),
    .first_common_line(first_common_line), .pixel_out(pixel_out), .irq(irq));
